// File: rdp_map.svh
// constants for the rf dac input port: widths, lane counts and reset values
// assumes inclusion by every design file that needs a number
`ifndef RDP_MAP_SVH
`define RDP_MAP_SVH
`define RDP_WORD_W        14
`define RDP_MAX_LANES     4
`define RDP_LANES_2TO1    2
`define RDP_LANES_4TO1    4
`define RDP_DLL_CNT_W     8
`define RDP_BUF_DEPTH     2
`define RDP_RST_WORD      14'h0000
`define RDP_RST_CNT       8'h00
`endif

// File: rdp_pkg.sv
// types shared by the rf dac input port modules
// assumes nothing beyond the constant header
`default_nettype none
package rdp_pkg;
  // serializer states, one-hot
  typedef enum logic [1:0] {
    RDP_IDLE  = 2'b01,
    RDP_SHIFT = 2'b10
  } rdp_state_t;
  // port multiplexing choice
  typedef enum logic {
    RDP_MUX_2TO1 = 1'b0,
    RDP_MUX_4TO1 = 1'b1
  } rdp_mux_t;
endpackage
`default_nettype wire

// File: rdp_stream_if.sv
// valid/ready carrier between the capture logic and its buffer
// assumes producer and consumer share one clock
`default_nettype none
interface rdp_stream_if #(parameter int WIDTH = 57);
  logic             valid;
  logic             ready;
  logic [WIDTH-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// File: rdp_word_buf.sv
// two-entry buffer holding captured lane groups ahead of the serializer
// assumes synchronous producer and consumer on clk_in
`default_nettype none
`include "rdp_map.svh"
module rdp_word_buf #(
  parameter int WIDTH = 57,
  parameter int DEPTH = `RDP_BUF_DEPTH
) (
  input  wire logic clk_in,        // conversion clock
  input  wire logic rst_n_in,      // async reset, active low
  rdp_stream_if.snk wr,            // filling side
  rdp_stream_if.src rd             // draining side
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wp_r, wp_nxt, rp_r, rp_nxt;
  logic [AW:0]      cnt_r, cnt_nxt;
  logic             do_wr, do_rd;

  // ----------------------------------------
  // handshake terms
  // ----------------------------------------
  // full and empty come straight from the count, so ready is honest
  assign wr.ready = (cnt_r != (AW+1)'(DEPTH));
  assign rd.valid = (cnt_r != '0);
  assign rd.data  = mem_r[rp_r];
  assign do_wr    = wr.valid && wr.ready;
  assign do_rd    = rd.valid && rd.ready;

  // pointer and count update
  always_comb begin
    wp_nxt  = wp_r;
    rp_nxt  = rp_r;
    cnt_nxt = cnt_r;
    if (do_wr) begin
      wp_nxt = (wp_r == AW'(DEPTH-1)) ? '0 : AW'(wp_r + 1'b1);
    end
    if (do_rd) begin
      rp_nxt = (rp_r == AW'(DEPTH-1)) ? '0 : AW'(rp_r + 1'b1);
    end
    case ({do_wr, do_rd})
      2'b10:   cnt_nxt = (AW+1)'(cnt_r + 1'b1);
      2'b01:   cnt_nxt = (AW+1)'(cnt_r - 1'b1);
      default: cnt_nxt = cnt_r;
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else begin
      wp_r  <= wp_nxt;
      rp_r  <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // storage has no reset: contents are only read while counted valid
  always_ff @(posedge clk_in) begin
    if (do_wr) begin
      mem_r[wp_r] <= wr.data;
    end
  end

  a_buf_no_overfill : assert property (@(posedge clk_in) disable iff (!rst_n_in)
    cnt_r <= (AW+1)'(DEPTH)) else $error("buffer count above depth");
endmodule // rdp_word_buf
`default_nettype wire

// File: rdp_input_port.sv
// digital input port of a 14-bit rf dac: lane capture, dll, parity, unscramble
// assumes all inputs synchronous to clk_in; input_data_clock sampled as data
`default_nettype none
`include "rdp_map.svh"
module rdp_input_port #(
  parameter int LANES  = `RDP_MAX_LANES,
  parameter int WORD_W = `RDP_WORD_W,
  parameter int CNT_W  = `RDP_DLL_CNT_W
) (
  input  wire logic                    clk_in,              // conversion clock pair, 10 MHz
  input  wire logic                    rst_n_in,            // async reset, active low
  input  wire logic                    input_data_clock_in, // source data clock, sampled
  input  wire logic [LANES*WORD_W-1:0] lane_data_in,        // lane words, lane 0 low
  input  wire logic [LANES-1:0]        lane_parity_in,      // parity bit per lane
  input  wire logic [LANES-1:0]        lane_key_in,         // whitening key per lane
  input  wire logic                    mux_4to1_in,         // 1: four lanes, 0: two
  input  wire logic                    ddr_en_in,           // 1: both data clock edges
  input  wire logic                    whiten_en_in,        // 1: undo xor whitening
  input  wire logic                    conv_ready_in,       // conversion stage accepts
  output logic                         src_ready_out,       // buffer has room
  output logic [WORD_W-1:0]            conv_word_out,       // word into conversion stage
  output logic                         conv_load_out,       // one-cycle load strobe
  output logic                         parity_err_out,      // parity error flag
  output logic                         dll_locked_out       // capture phase settled
);
  localparam int GRP_W = LANES*WORD_W + 1;
  localparam int IDX_W = (LANES > 1) ? $clog2(LANES) : 1;

  // ----------------------------------------
  // dll: edge timing and mid-eye capture
  // ----------------------------------------
  logic             data_clk_prev_r, data_clk_prev_nxt;
  logic [CNT_W-1:0] since_r, since_nxt, interval_r, interval_nxt, half;
  logic             locked_r, locked_nxt, data_event, capture;

  // sdr launches on rising data clock edges only, ddr on both
  assign data_event = ddr_en_in ? (input_data_clock_in ^ data_clk_prev_r)
                                : (input_data_clock_in & ~data_clk_prev_r);
  assign half       = CNT_W'((CNT_W+1)'(interval_r) + 1'b1 >> 1);
  // sample halfway between launches so the eye is centred on our edge
  assign capture    = locked_r && !data_event && since_r == half;

  // edge spacing is measured and must repeat before the phase is trusted
  always_comb begin
    data_clk_prev_nxt = input_data_clock_in;
    since_nxt     = (since_r == '1) ? since_r : CNT_W'(since_r + 1'b1);
    interval_nxt  = interval_r;
    locked_nxt    = locked_r;
    if (data_event) begin
      since_nxt    = '0;
      interval_nxt = since_r;
      locked_nxt   = (since_r == interval_r) && (since_r != '0);
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      data_clk_prev_r <= 1'b0;
      since_r     <= `RDP_RST_CNT;
      interval_r  <= `RDP_RST_CNT;
      locked_r    <= 1'b0;
    end else begin
      data_clk_prev_r <= data_clk_prev_nxt;
      since_r     <= since_nxt;
      interval_r  <= interval_nxt;
      locked_r    <= locked_nxt;
    end
  end
  assign dll_locked_out = locked_r;

  // ----------------------------------------
  // parity check and unscrambling
  // ----------------------------------------
  logic [LANES-1:0]        lane_bad;
  logic                    any_bad;
  logic [LANES*WORD_W-1:0] clear_data;
  logic                    err_r, err_nxt;
  int                      act_lanes;

  // parity covers the bits as sent, so it is checked before unscrambling
  always_comb begin
    act_lanes  = mux_4to1_in ? `RDP_LANES_4TO1 : `RDP_LANES_2TO1;
    lane_bad   = '0;
    clear_data = lane_data_in;
    for (int l = 0; l < LANES; l++) begin
      if (l < act_lanes) begin
        // even parity: data bits plus parity bit xor to zero
        lane_bad[l] = (^lane_data_in[l*WORD_W +: WORD_W]) ^ lane_parity_in[l];
      end
      if (whiten_en_in) begin
        clear_data[l*WORD_W +: WORD_W] = lane_data_in[l*WORD_W +: WORD_W]
                                         ^ {WORD_W{lane_key_in[l]}};
      end
    end
    any_bad = |lane_bad;
    // flag follows the latest captured group and holds between captures
    err_nxt = capture ? any_bad : err_r;
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      err_r <= 1'b0;
    end else begin
      err_r <= err_nxt;
    end
  end
  assign parity_err_out = err_r;

  // ----------------------------------------
  // group buffer
  // ----------------------------------------
  rdp_stream_if #(.WIDTH(GRP_W)) push_if ();
  rdp_stream_if #(.WIDTH(GRP_W)) pop_if ();

  assign push_if.valid = capture;
  assign push_if.data  = {mux_4to1_in, clear_data};
  assign src_ready_out = push_if.ready;

  rdp_word_buf #(
    .WIDTH (GRP_W),
    .DEPTH (`RDP_BUF_DEPTH)
  ) u_buf (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .wr       (push_if),
    .rd       (pop_if)
  );

  // ----------------------------------------
  // serializer into the conversion stage
  // ----------------------------------------
  rdp_pkg::rdp_state_t st_r, st_nxt;
  logic [GRP_W-1:0]    grp_r, grp_nxt;
  logic [IDX_W-1:0]    idx_r, idx_nxt, last_idx;
  logic [WORD_W-1:0]   word_r, word_nxt, sel_word;
  logic                load_r, load_nxt;

  assign pop_if.ready = (st_r == rdp_pkg::RDP_IDLE);
  assign last_idx     = (grp_r[GRP_W-1] == rdp_pkg::RDP_MUX_4TO1)
                        ? IDX_W'(`RDP_LANES_4TO1 - 1) : IDX_W'(`RDP_LANES_2TO1 - 1);
  assign sel_word     = grp_r[int'(idx_r)*WORD_W +: WORD_W];

  // one lane word per conversion edge while the conversion stage accepts
  always_comb begin
    st_nxt   = st_r;
    grp_nxt  = grp_r;
    idx_nxt  = idx_r;
    word_nxt = word_r;
    load_nxt = 1'b0;
    case (st_r)
      rdp_pkg::RDP_IDLE: begin
        if (pop_if.valid) begin
          grp_nxt = pop_if.data;
          idx_nxt = '0;
          st_nxt  = rdp_pkg::RDP_SHIFT;
        end
      end
      rdp_pkg::RDP_SHIFT: begin
        if (conv_ready_in) begin
          word_nxt = sel_word;
          load_nxt = 1'b1;
          idx_nxt  = IDX_W'(idx_r + 1'b1);
          if (idx_r == last_idx) begin
            st_nxt = rdp_pkg::RDP_IDLE;
          end
        end
      end
      default: st_nxt = rdp_pkg::RDP_IDLE;
    endcase
  end

  // the word register is the conversion latch, clocked on the rising edge
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_r   <= rdp_pkg::RDP_IDLE;
      grp_r  <= '0;
      idx_r  <= '0;
      word_r <= `RDP_RST_WORD;
      load_r <= 1'b0;
    end else begin
      st_r   <= st_nxt;
      grp_r  <= grp_nxt;
      idx_r  <= idx_nxt;
      word_r <= word_nxt;
      load_r <= load_nxt;
    end
  end
  assign conv_word_out = word_r;
  assign conv_load_out = load_r;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  a_load_from_shift : assert property (conv_load_out |->
    $past(st_r == rdp_pkg::RDP_SHIFT && conv_ready_in)) else $error("load without shift");
  a_load_word_match : assert property (st_r == rdp_pkg::RDP_SHIFT && conv_ready_in
    |=> conv_load_out && conv_word_out == $past(sel_word)) else $error("wrong word loaded");
  a_mux_two_lanes : assert property (st_r == rdp_pkg::RDP_SHIFT && !grp_r[GRP_W-1]
    |-> idx_r < IDX_W'(`RDP_LANES_2TO1)) else $error("2:1 group used too many lanes");
  a_dll_mid_eye : assert property (capture |-> locked_r && since_r != '0
    && !data_event) else $error("capture outside data eye");
  a_dll_lock_loss : assert property (data_event && since_r != interval_r
    |=> !dll_locked_out) else $error("lock kept after period change");
  a_sdr_no_fall : assert property (!ddr_en_in && data_clk_prev_r && !input_data_clock_in
    |-> !data_event) else $error("sdr reacted to falling edge");
  a_parity_flag : assert property (capture && any_bad
    |=> parity_err_out) else $error("parity error not flagged");
  a_parity_clean : assert property (capture && !any_bad
    |=> !parity_err_out) else $error("false parity error");
  a_unwhiten_lane0 : assert property (capture && whiten_en_in
    |-> push_if.data[WORD_W-1:0] == (lane_data_in[WORD_W-1:0] ^ {WORD_W{lane_key_in[0]}}))
    else $error("lane 0 not unscrambled");
  a_group_drains : assert property (st_r == rdp_pkg::RDP_SHIFT && conv_ready_in
    [*4] |=> st_r == rdp_pkg::RDP_IDLE || $past(st_r == rdp_pkg::RDP_IDLE))
    else $error("group longer than four words");

  c_four_lane : cover property (capture && mux_4to1_in ##[1:200] conv_load_out);
  c_parity_err : cover property (capture && any_bad);
  c_buf_stall : cover property (!src_ready_out ##1 src_ready_out);
  c_ddr_lock : cover property (ddr_en_in && $rose(dll_locked_out));
endmodule // rdp_input_port
`default_nettype wire

// File: rdp_src_model.sv
// data source model: data clock, lane words, even parity and whitening key
// assumes it shares clk_in with the port; launches are HALF cycles apart in ddr, twice that in sdr
`default_nettype none
module rdp_src_model #(
  parameter int HALF = 4
) (
  input  wire logic        clk_in,     // conversion clock
  input  wire logic        rst_n_in,   // async reset, active low
  input  wire logic        run_in,     // 1: data clock toggles
  input  wire logic        ddr_in,     // 1: launch on both data clock edges
  input  wire logic        white_in,   // 1: scramble lanes with their key
  input  wire logic [3:0]  key_in,     // key bit per lane
  input  wire logic [3:0]  bad_par_in, // 1: send wrong parity on that lane
  input  wire logic [55:0] grp_in,     // plain lane words, lane 0 low
  output logic             data_clk_out, // data clock
  output logic [55:0]      lane_out,   // lane words on the wire
  output logic [3:0]       par_out,    // parity per lane
  output logic [3:0]       key_out     // key per lane
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0]  cnt_r;
  logic [55:0] wire_w;
  logic [3:0]  par_w;
  // parity is formed over the scrambled bits, as they cross the wire
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      wire_w[i*14 +: 14] = grp_in[i*14 +: 14] ^ {14{white_in & key_in[i]}};
      par_w[i]           = (^wire_w[i*14 +: 14]) ^ bad_par_in[i];
    end
  end
  // clock stands still outside runs; data changes only at a launch
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_r    <= 8'h00;
      data_clk_out <= 1'b0;
      lane_out <= 56'h0;
      par_out  <= 4'h0;
      key_out  <= 4'h0;
    end else if (run_in) begin
      cnt_r <= (cnt_r == 8'(HALF - 1)) ? 8'h00 : cnt_r + 8'h01;
      if (cnt_r == 8'(HALF - 1)) begin
        data_clk_out <= ~data_clk_out;
        if (ddr_in || !data_clk_out) begin
          lane_out <= wire_w;
          par_out  <= par_w;
          key_out  <= key_in;
        end
      end
    end
  end
endmodule // rdp_src_model
`default_nettype wire

// File: test_rf_dac_input_port.sv
// self-checking bench for the rf dac input port with a data source model
// assumes the port's hand-over timing: words appear one per cycle on load
`default_nettype none
module test_rf_dac_input_port;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_in = 1'b0;
  logic        rst_n_in = 1'b0;
  logic        run = 1'b0, mux = 1'b0, ddr = 1'b0, white = 1'b0, rdy = 1'b0;
  logic [3:0]  kin = 4'h0, bad = 4'h0, par, key;
  logic [55:0] grp = {14'h2D3C, 14'h1A5B, 14'h3FFF, 14'h0001};
  logic [55:0] lanes;
  logic        data_clk, sready, load, perr, lock;
  logic [13:0] word;
  int          fail_count = 0;
  int          cmp_count = 0;
  always #50 clk_in = ~clk_in;
  rdp_src_model src_u (.clk_in(clk_in), .rst_n_in(rst_n_in), .run_in(run), .ddr_in(ddr),
    .white_in(white), .key_in(kin), .bad_par_in(bad), .grp_in(grp), .data_clk_out(data_clk),
    .lane_out(lanes), .par_out(par), .key_out(key));
  rdp_input_port dut_u (.clk_in(clk_in), .rst_n_in(rst_n_in), .input_data_clock_in(data_clk),
    .lane_data_in(lanes), .lane_parity_in(par), .lane_key_in(key), .mux_4to1_in(mux),
    .ddr_en_in(ddr), .whiten_en_in(white), .conv_ready_in(rdy), .src_ready_out(sready),
    .conv_word_out(word), .conv_load_out(load), .parity_err_out(perr),
    .dll_locked_out(lock));
  task automatic complete_run;
    if (fail_count == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk_word(input logic [13:0] got, input logic [13:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_flag(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // reset, set the mode pins, then let the source run
  task automatic start(input logic m, input logic d, input logic w, input logic [3:0] k,
                       input logic [3:0] b);
    @(posedge clk_in);
    rst_n_in <= 1'b0;
    run <= 1'b0;
    rdy <= 1'b0;
    mux <= m;
    ddr <= d;
    white <= w;
    kin <= k;
    bad <= b;
    repeat (8) @(posedge clk_in);
    rst_n_in <= 1'b1;
    @(posedge clk_in);
    run <= 1'b1;
  endtask
  // wait, bounded, for the next load pulse and judge the word it carries
  task automatic get_word(input int lane);
    int n;
    n = 0;
    do begin
      @(posedge clk_in);
      #1;
      n++;
    end while (load !== 1'b1 && n < 300);
    chk_flag(load, 1'b1);
    chk_word(word, grp[lane*14 +: 14]);
  endtask
  // sdr 2:1, two groups back to back; a bad parity on an unused lane is ignored
  task automatic t_sdr_2to1;
    start(1'b0, 1'b0, 1'b0, 4'h0, 4'h8);
    rdy <= 1'b1;
    for (int i = 0; i < 4; i++) get_word(i % 2);
    chk_flag(lock, 1'b1);
    chk_flag(perr, 1'b0);
  endtask
  // ddr 4:1 with whitening: the words come back unscrambled, in lane order
  task automatic t_ddr_4to1_white;
    start(1'b1, 1'b1, 1'b1, 4'h5, 4'h0);
    rdy <= 1'b1;
    for (int i = 0; i < 8; i++) get_word(i % 4);
    chk_flag(perr, 1'b0);
  endtask
  // wrong parity on lane 1 raises the flag; good groups clear it again
  task automatic t_parity;
    start(1'b1, 1'b0, 1'b0, 4'h0, 4'h2);
    rdy <= 1'b1;
    get_word(0);
    chk_flag(perr, 1'b1);
    bad <= 4'h0;
    for (int i = 1; i < 16; i++) get_word(i % 4);
    chk_flag(perr, 1'b0);
  endtask
  // receiver stalls: the buffer fills and refuses, then drains without loss
  task automatic t_stall;
    int n;
    start(1'b0, 1'b0, 1'b0, 4'h0, 4'h0);
    n = 0;
    do begin
      @(posedge clk_in);
      #1;
      n++;
    end while (sready !== 1'b0 && n < 300);
    chk_flag(sready, 1'b0);
    @(posedge clk_in);
    rdy <= 1'b1;
    // the held group and both buffered groups come out in lane order
    for (int i = 0; i < 6; i++) get_word(i % 2);
    chk_flag(sready, 1'b1);
  endtask
  // watchdog: all tests need well under 4000 cycles
  initial begin
    repeat (20000) @(posedge clk_in);
    fail_count++;
    complete_run();
  end
  // values held in reset, then each scenario in turn
  initial begin
    repeat (8) @(posedge clk_in);
    #1;
    chk_flag(sready, 1'b1);
    chk_flag(load, 1'b0);
    chk_flag(perr, 1'b0);
    chk_flag(lock, 1'b0);
    chk_word(word, 14'h0000);
    t_sdr_2to1();
    t_ddr_4to1_white();
    t_parity();
    t_stall();
    complete_run();
  end
endmodule // test_rf_dac_input_port
`default_nettype wire
